// >>> logic/ipc_regs.svh
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH
// Word offsets on the AXI4-Lite slave
`define IPC_OFS_GCTRL 8'h00
`define IPC_OFS_ECTRL 8'h04
`define IPC_OFS_XCTRL 8'h08
`define IPC_OFS_PCHG 8'h0C
`define IPC_OFS_PRI1 8'h10
`define IPC_OFS_PRI2 8'h14
`define IPC_OFS_PRI3 8'h18
`define IPC_OFS_PRI4 8'h1C
`define IPC_OFS_PRI5 8'h20
`define IPC_OFS_EN1 8'h24
`define IPC_OFS_EN2 8'h28
`define IPC_OFS_EN3 8'h2C
`define IPC_OFS_EN4 8'h30
`define IPC_OFS_EN5 8'h34
`define IPC_OFS_FLG1 8'h38
`define IPC_OFS_FLG2 8'h3C
`define IPC_OFS_FLG3 8'h40
`define IPC_OFS_FLG4 8'h44
`define IPC_OFS_FLG5 8'h48
`define IPC_OFS_RSTC 8'h4C
`define IPC_OFS_TMR0 8'h50
// Global control bits
`define IPC_G_GHE 7
`define IPC_G_PLE 6
`define IPC_G_T0E 5
`define IPC_G_X0E 4
`define IPC_G_PCE 3
`define IPC_G_T0F 2
`define IPC_G_X0F 1
`define IPC_G_PCF 0
// Edge and priority control bits
`define IPC_E_PUD 7
`define IPC_E_EDG0 6
`define IPC_E_EDG1 5
`define IPC_E_EDG2 4
`define IPC_E_T0P 2
`define IPC_E_PCP 0
// External control bits, then the priority-enable and timer-width bits
`define IPC_X_P2 7
`define IPC_X_P1 6
`define IPC_X_E2 4
`define IPC_X_E1 3
`define IPC_X_F2 1
`define IPC_X_F1 0
`define IPC_R_PEN 7
`define IPC_T0_W16 8
// Implemented-bit masks and reset values
`define IPC_MASK_PRI1 8'h7F
`define IPC_MASK_SMALL 8'h07
`define IPC_MASK_PCHG 8'hF0
`define IPC_MASK_ECTRL 8'hF5
`define IPC_MASK_XCTRL 8'hDB
`define IPC_RST_ECTRL 8'hF5
`define IPC_RST_XCTRL 8'hC0
`define IPC_RST_PRI1 8'h7F
`define IPC_RST_PRI2 8'hFF
`define IPC_RST_PRI3 8'h00
`define IPC_RST_PRI45 8'h00
`define IPC_VEC_HIGH 16'h0008
`define IPC_VEC_LOW 16'h0018
`endif

// >>> logic/ipc_pkg.sv
package ipc_pkg;
  typedef enum logic [1:0] {
    IPC_IDLE = 2'b00,
    IPC_HIGH = 2'b01,
    IPC_LOW = 2'b11,
    IPC_LHI = 2'b10
  } ipc_svc_t;

  typedef struct packed {
    logic [15:0] ret_pc;
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] bank_select_register;
  } ipc_ctx_t;

  typedef struct packed {
    logic [7:0] gctrl;
    logic [7:0] ectrl;
    logic [7:0] xctrl;
    logic [7:0] pchg;
    logic [4:0][7:0] pri;
    logic [4:0][7:0] en;
    logic [4:0][7:0] flg;
    logic pri_en;
    logic t0_w16;
    logic [15:0] t0_prev;
    logic [2:0] pin_prev;
    logic [3:0] pb_prev;
    logic [2:0] wake_arm;
    ipc_svc_t svc;
    ipc_ctx_t ctx;
    logic [15:0] vec;
    logic vec_valid;
    logic wake;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipc_state_t;
endpackage

// >>> logic/ipc_ctrl.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ipc_regs.svh"
// Overview of operation
// - Fourth priority register: bits 2..0 for compare 5,4,3; upper bits zero.
// - Fifth priority register: bits 2..0 for timer 6, 5, 4; reset zero.
// - External pins trigger on edge; select 1 rising, 0 falling.
// - Selected edge sets pin flag; enable bit gates it from interrupting.
// - Pin wakes from idle or sleep only if enabled before entry.
// - After wake, vector only when global enable set, else continue.
// - External 1 and 2 priority from third control register bits 6, 7.
// - External 0 has no priority bit; always high priority.
// - Timer-0 flag on FFh to 00h wrap, or FFFFh to 0000h in 16-bit.
// - Timer-0 interrupt gated by its enable, priority from second register.
// - Change on port-B pins 7..4 with their per-pin enable set sets the port-change flag.
// - Port change needs common and per-pin enable; priority from register two.
// - On entry push return address, save working, status and bank registers.
// - Main control register layout: enables high to low, then three flags.
// - Second register: pull-up disable, edge selects, timer-0 and change priority.
// - Priority bits only act while the priority-enable bit is set.
// - First three priority registers: one bit per source, 1 is high.
module ipc_ctrl
  import ipc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [2:0] ext_pin_in,
  input wire logic [7:4] port_b_in,
  input wire logic [15:0] timer0_count_in,
  input wire logic [4:0][7:0] periph_event_in,
  input wire logic low_power_in,
  input wire logic [15:0] core_pc_in,
  input wire logic [7:0] working_register_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] bank_select_register_in,
  input wire logic vec_ack_in,
  input wire logic ret_high_in,
  input wire logic ret_low_in,
  output logic vec_valid_out,
  output logic [15:0] vec_addr_out,
  output logic wake_out,
  output logic port_pullup_disable_out,
  output ipc_ctx_t ctx_out
);

  ipc_state_t s_reg;
  ipc_state_t s_next;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] st, input logic [7:0] msk);
    merge = st[0] ? (d[7:0] & msk) : old;
  endfunction

  // Only aligned words inside the map answer OKAY
  function automatic logic ofs_ok(input logic [7:0] ofs);
    ofs_ok = ofs <= `IPC_OFS_TMR0 && ofs[1:0] == 2'b00;
  endfunction

  logic [2:0] ext_edge_select;
  logic [2:0] ext_pin_flag;
  logic [2:0] ext_pin_enable;
  logic [2:0] ext_hit;
  logic [2:0] ext_hi;
  logic t0_wrap;
  logic pb_chg;
  logic [4:0][7:0] per_act;
  logic per_hi;
  logic per_lo;
  logic src_hi;
  logic src_lo;
  logic take_hi;
  logic take_lo;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic wr_ok;
  logic do_wr;
  logic [7:0] wv;

  assign ext_edge_select = {s_reg.ectrl[`IPC_E_EDG2], s_reg.ectrl[`IPC_E_EDG1],
                            s_reg.ectrl[`IPC_E_EDG0]};
  assign ext_pin_flag = {s_reg.xctrl[`IPC_X_F2], s_reg.xctrl[`IPC_X_F1],
                         s_reg.gctrl[`IPC_G_X0F]};
  assign ext_pin_enable = {s_reg.xctrl[`IPC_X_E2], s_reg.xctrl[`IPC_X_E1],
                           s_reg.gctrl[`IPC_G_X0E]};
  assign ext_hit = (ext_edge_select & ext_pin_in & ~s_reg.pin_prev)
                 | (~ext_edge_select & ~ext_pin_in & s_reg.pin_prev);
  // wrap to zero
  // 8-bit mode looks at the low byte only; the high byte may run free
  assign t0_wrap = s_reg.t0_w16 ? (s_reg.t0_prev == 16'hFFFF && timer0_count_in == 16'h0000)
                                : (s_reg.t0_prev[7:0] == 8'hFF && timer0_count_in[7:0] == 8'h00);
  assign pb_chg = |((port_b_in ^ s_reg.pb_prev) & s_reg.pchg[7:4]);

  assign ext_hi = s_reg.pri_en ? {s_reg.xctrl[`IPC_X_P2], s_reg.xctrl[`IPC_X_P1], 1'b1}
                               : 3'b111;
  // Peripheral sources share one request per level, no own vectors
  assign per_act = s_reg.flg & s_reg.en;
  assign per_hi = |(per_act & s_reg.pri);
  assign per_lo = |(per_act & ~s_reg.pri);

  always_comb
  begin
    logic core_hi;
    logic core_lo;
    logic t0_on;
    logic pc_on;
    core_hi = 1'b0;
    core_lo = 1'b0;
    t0_on = s_reg.gctrl[`IPC_G_T0F] & s_reg.gctrl[`IPC_G_T0E];
    pc_on = s_reg.gctrl[`IPC_G_PCF] & s_reg.gctrl[`IPC_G_PCE];
    core_hi = |(ext_pin_flag & ext_pin_enable & ext_hi)
            | (t0_on & s_reg.ectrl[`IPC_E_T0P]) | (pc_on & s_reg.ectrl[`IPC_E_PCP]);
    core_lo = |(ext_pin_flag & ext_pin_enable & ~ext_hi)
            | (t0_on & ~s_reg.ectrl[`IPC_E_T0P]) | (pc_on & ~s_reg.ectrl[`IPC_E_PCP]);
    if (s_reg.pri_en)
    begin
      src_hi = core_hi | per_hi;
      src_lo = core_lo | per_lo;
    end
    else
    begin
      // single vector, peripherals behind their own enable
      src_hi = core_hi | core_lo | (s_reg.gctrl[`IPC_G_PLE] & (per_hi | per_lo));
      src_lo = 1'b0;
    end
  end

  assign take_hi = src_hi & s_reg.gctrl[`IPC_G_GHE]
                 & (s_reg.svc == IPC_IDLE || s_reg.svc == IPC_LOW) & ~s_reg.vec_valid;
  assign take_lo = src_lo & s_reg.pri_en & s_reg.gctrl[`IPC_G_GHE] & s_reg.gctrl[`IPC_G_PLE]
                 & ~take_hi & s_reg.svc == IPC_IDLE & ~s_reg.vec_valid;

  // Readies come from registered state only, no input to output path
  assign s_axi_awready_out = ~s_reg.aw_full & ~s_reg.bvalid;
  assign s_axi_wready_out = ~s_reg.w_full & ~s_reg.bvalid;
  assign s_axi_arready_out = ~s_reg.rvalid;
  assign do_wr = s_reg.aw_full & s_reg.w_full & ~s_reg.bvalid;
  assign wr_ofs = s_reg.aw_addr;
  assign rd_ofs = 8'(s_axi_araddr_in);
  assign wr_ok = ofs_ok(wr_ofs);

  always_comb
  begin
    // Read data is captured at address accept and does not track later changes
    rd_ok = ofs_ok(rd_ofs);
    case (rd_ofs)
      `IPC_OFS_GCTRL: rd_byte = s_reg.gctrl;
      `IPC_OFS_ECTRL: rd_byte = s_reg.ectrl;
      `IPC_OFS_XCTRL: rd_byte = s_reg.xctrl;
      `IPC_OFS_PCHG: rd_byte = s_reg.pchg;
      `IPC_OFS_PRI1: rd_byte = s_reg.pri[0];
      `IPC_OFS_PRI2: rd_byte = s_reg.pri[1];
      `IPC_OFS_PRI3: rd_byte = s_reg.pri[2];
      `IPC_OFS_PRI4: rd_byte = s_reg.pri[3];
      `IPC_OFS_PRI5: rd_byte = s_reg.pri[4];
      `IPC_OFS_EN1: rd_byte = s_reg.en[0];
      `IPC_OFS_EN2: rd_byte = s_reg.en[1];
      `IPC_OFS_EN3: rd_byte = s_reg.en[2];
      `IPC_OFS_EN4: rd_byte = s_reg.en[3];
      `IPC_OFS_EN5: rd_byte = s_reg.en[4];
      `IPC_OFS_FLG1: rd_byte = s_reg.flg[0];
      `IPC_OFS_FLG2: rd_byte = s_reg.flg[1];
      `IPC_OFS_FLG3: rd_byte = s_reg.flg[2];
      `IPC_OFS_FLG4: rd_byte = s_reg.flg[3];
      `IPC_OFS_FLG5: rd_byte = s_reg.flg[4];
      `IPC_OFS_RSTC: rd_byte = {s_reg.pri_en, 7'h00};
      `IPC_OFS_TMR0: rd_byte = {7'h00, s_reg.t0_w16};
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    wv = 8'h00;
    // Previous samples feed the edge, wrap and change detectors
    s_next.pin_prev = ext_pin_in;
    s_next.pb_prev = port_b_in;
    s_next.t0_prev = timer0_count_in;
    s_next.wake = 1'b0;
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = 8'(s_axi_awaddr_in);
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata_in;
      s_next.w_strb = s_axi_wstrb_in;
    end
    // Software writes first so that hardware sets below win over a clear
    if (do_wr)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_ok ? 2'b00 : 2'b10;
      // Only byte lane 0 carries register bits; upper lanes are ignored
      wv = s_reg.w_data[7:0];
      if (s_reg.w_strb[0])
      begin
        case (wr_ofs)
          `IPC_OFS_GCTRL: s_next.gctrl = wv;
          `IPC_OFS_ECTRL: s_next.ectrl = merge(s_reg.ectrl, s_reg.w_data, s_reg.w_strb,
                                               `IPC_MASK_ECTRL);
          `IPC_OFS_XCTRL: s_next.xctrl = merge(s_reg.xctrl, s_reg.w_data, s_reg.w_strb,
                                               `IPC_MASK_XCTRL);
          `IPC_OFS_PCHG: s_next.pchg = merge(s_reg.pchg, s_reg.w_data, s_reg.w_strb,
                                             `IPC_MASK_PCHG);
          `IPC_OFS_PRI1: s_next.pri[0] = merge(s_reg.pri[0], s_reg.w_data, s_reg.w_strb,
                                               `IPC_MASK_PRI1);
          `IPC_OFS_PRI2: s_next.pri[1] = wv;
          `IPC_OFS_PRI3: s_next.pri[2] = wv;
          `IPC_OFS_PRI4: s_next.pri[3] = merge(s_reg.pri[3], s_reg.w_data, s_reg.w_strb,
                                               `IPC_MASK_SMALL);
          `IPC_OFS_PRI5: s_next.pri[4] = merge(s_reg.pri[4], s_reg.w_data, s_reg.w_strb,
                                               `IPC_MASK_SMALL);
          `IPC_OFS_EN1: s_next.en[0] = wv & `IPC_MASK_PRI1;
          `IPC_OFS_EN2: s_next.en[1] = wv;
          `IPC_OFS_EN3: s_next.en[2] = wv;
          `IPC_OFS_EN4: s_next.en[3] = wv & `IPC_MASK_SMALL;
          `IPC_OFS_EN5: s_next.en[4] = wv & `IPC_MASK_SMALL;
          `IPC_OFS_FLG1: s_next.flg[0] = wv & `IPC_MASK_PRI1;
          `IPC_OFS_FLG2: s_next.flg[1] = wv;
          `IPC_OFS_FLG3: s_next.flg[2] = wv;
          `IPC_OFS_FLG4: s_next.flg[3] = wv & `IPC_MASK_SMALL;
          `IPC_OFS_FLG5: s_next.flg[4] = wv & `IPC_MASK_SMALL;
          `IPC_OFS_RSTC: s_next.pri_en = wv[`IPC_R_PEN];
          `IPC_OFS_TMR0: s_next.t0_w16 = wv[0];
          // Unmapped offsets answer an error and change nothing
          default: s_next.bresp = 2'b10;
        endcase
      end
    end
    if (s_reg.bvalid && s_axi_bready_in)
    begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = {24'h000000, rd_byte};
      s_next.rresp = rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_reg.rvalid && s_axi_rready_in)
    begin
      s_next.rvalid = 1'b0;
    end
    if (ext_hit[0])
    begin
      s_next.gctrl[`IPC_G_X0F] = 1'b1;
    end
    if (ext_hit[1])
    begin
      s_next.xctrl[`IPC_X_F1] = 1'b1;
    end
    if (ext_hit[2])
    begin
      s_next.xctrl[`IPC_X_F2] = 1'b1;
    end
    if (t0_wrap)
    begin
      s_next.gctrl[`IPC_G_T0F] = 1'b1;
    end
    if (pb_chg)
    begin
      s_next.gctrl[`IPC_G_PCF] = 1'b1;
    end
    // Unimplemented flag bits never set, so they keep reading zero
    s_next.flg = s_next.flg | (periph_event_in
               & {`IPC_MASK_SMALL, `IPC_MASK_SMALL, 8'hFF, 8'hFF, `IPC_MASK_PRI1});
    // arm only if enabled before low power
    // Enables freeze at entry; writes made while asleep cannot arm a wake
    if (!low_power_in)
    begin
      s_next.wake_arm = ext_pin_enable;
    end
    else if (|(ext_hit & s_reg.wake_arm))
    begin
      s_next.wake = 1'b1;
    end
    // flag must be cleared by software; no hardware auto-clear
    // Request holds until the core takes it; no second vector meanwhile
    if (s_reg.vec_valid && vec_ack_in)
    begin
      s_next.vec_valid = 1'b0;
    end
    if (take_hi || take_lo)
    begin
      s_next.vec_valid = 1'b1;
      s_next.vec = take_hi ? `IPC_VEC_HIGH : `IPC_VEC_LOW;
      s_next.ctx.ret_pc = core_pc_in;
      s_next.ctx.working_register = working_register_in;
      s_next.ctx.status = status_in;
      s_next.ctx.bank_select_register = bank_select_register_in;
    end
    // Return strobes from the core unwind the nesting
    case (s_reg.svc)
      IPC_IDLE: s_next.svc = take_hi ? IPC_HIGH : (take_lo ? IPC_LOW : IPC_IDLE);
      IPC_HIGH: s_next.svc = ret_high_in ? IPC_IDLE : IPC_HIGH;
      IPC_LOW: s_next.svc = take_hi ? IPC_LHI : (ret_low_in ? IPC_IDLE : IPC_LOW);
      IPC_LHI: s_next.svc = ret_high_in ? IPC_LOW : IPC_LHI;
      default: s_next.svc = IPC_IDLE;
    endcase
    if (srst_in)
    begin
      s_next = '0;
      s_next.ectrl = `IPC_RST_ECTRL;
      s_next.xctrl = `IPC_RST_XCTRL;
      s_next.pri[0] = `IPC_RST_PRI1;
      s_next.pri[1] = `IPC_RST_PRI2;
      s_next.pri[2] = `IPC_RST_PRI3;
      s_next.pri[3] = `IPC_RST_PRI45;
      s_next.pri[4] = `IPC_RST_PRI45;
      // Seed the detectors with live inputs so reset gives no false edge
      s_next.pin_prev = ext_pin_in;
      s_next.pb_prev = port_b_in;
      s_next.t0_prev = timer0_count_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    s_reg <= s_next;
  end

  assign s_axi_bvalid_out = s_reg.bvalid;
  assign s_axi_bresp_out = s_reg.bresp;
  assign s_axi_rvalid_out = s_reg.rvalid;
  assign s_axi_rdata_out = s_reg.rdata;
  assign s_axi_rresp_out = s_reg.rresp;
  assign vec_valid_out = s_reg.vec_valid;
  assign vec_addr_out = s_reg.vec;
  assign wake_out = s_reg.wake;
  assign port_pullup_disable_out = s_reg.ectrl[`IPC_E_PUD];
  assign ctx_out = s_reg.ctx;

endmodule

// >>> test/ipc_ctrl_properties.sv
`timescale 1ns/1ps
`include "ipc_regs.svh"
module ipc_ctrl_properties
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic low_power_in,
  input wire logic vec_ack_in,
  input wire logic vec_valid_out,
  input wire logic [15:0] vec_addr_out,
  input wire logic wake_out
);
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  a_vec_holds:
    assert property (vec_valid_out && !vec_ack_in |=> vec_valid_out && $stable(vec_addr_out))
      else $error("vector request changed before acknowledge");
  a_ack_drops:
    assert property (vec_valid_out && vec_ack_in |=> !vec_valid_out)
      else $error("vector request still up after acknowledge");
  a_vec_legal:
    assert property (vec_valid_out |-> vec_addr_out inside {`IPC_VEC_HIGH, `IPC_VEC_LOW})
      else $error("vector address not a known vector");
  a_wake_pulse:
    assert property (wake_out |=> !wake_out)
      else $error("wake longer than one cycle");
  a_wake_asleep:
    assert property (wake_out |-> $past(low_power_in))
      else $error("wake while not in low power");
  a_write_done:
    assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write response repeated");
  a_read_answer:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
  a_read_done:
    assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
      else $error("read response repeated");
endmodule

bind ipc_ctrl ipc_ctrl_properties u_props (
  .mclk_in(mclk_in), .srst_in(srst_in), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .low_power_in(low_power_in), .vec_ack_in(vec_ack_in),
  .vec_valid_out(vec_valid_out), .vec_addr_out(vec_addr_out), .wake_out(wake_out));

// >>> test/ipc_core_model.sv
`timescale 1ns/1ps
module ipc_core_model
  import ipc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic vec_valid_in,
  input wire logic [3:0] delay_in,
  output logic vec_ack_out,
  output ipc_ctx_t ctx_out
);
  logic [3:0] cnt;
  // Held still so the capture moment cannot matter
  assign ctx_out = {16'h1234, 8'h5A, 8'hC3, 8'h0F};
  // Slow cores hold off the acknowledge
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !vec_valid_in || vec_ack_out)
    begin
      cnt <= 4'h0;
      vec_ack_out <= 1'b0;
    end
    else if (cnt == delay_in)
      vec_ack_out <= 1'b1;
    else
      cnt <= cnt + 4'h1;
  end
endmodule

// >>> test/interrupt_priority_and_sources_tb_top.sv
`timescale 1ns/1ps
`include "ipc_regs.svh"
module interrupt_priority_and_sources_tb_top;
  import ipc_pkg::*;
  logic mclk_in = 0;
  logic srst_in = 1;
  logic [7:0] aa = 0;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, lp = 0, rh = 0, rl = 0;
  logic awr, wr, bv, arr, rv, vv, wk, pud, ack;
  logic [1:0] br, rr;
  logic [31:0] rdo, rd;
  logic [2:0] pins = 0;
  logic [7:4] pb = 0;
  logic [4:0][7:0] pev = '0;
  logic [3:0] dly = 0;
  logic [15:0] t0 = 0, va;
  ipc_ctx_t cx, cc;
  int fail_count = 0, comparisons = 0, wakes = 0;
  logic [7:0] ra [10] = '{`IPC_OFS_GCTRL, `IPC_OFS_ECTRL, `IPC_OFS_XCTRL, `IPC_OFS_PCHG,
    `IPC_OFS_PRI1, `IPC_OFS_PRI2, `IPC_OFS_PRI3, `IPC_OFS_PRI4, `IPC_OFS_PRI5, `IPC_OFS_RSTC};
  logic [7:0] rv_tab [10] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00};

  ipc_ctrl dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .s_axi_awaddr_in(aa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_araddr_in(aa), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdo), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .ext_pin_in(pins), .port_b_in(pb), .timer0_count_in(t0), .periph_event_in(pev),
    .low_power_in(lp), .core_pc_in(cc.ret_pc), .working_register_in(cc.working_register),
    .status_in(cc.status), .bank_select_register_in(cc.bank_select_register), .vec_ack_in(ack),
    .ret_high_in(rh), .ret_low_in(rl), .vec_valid_out(vv), .vec_addr_out(va),
    .wake_out(wk), .port_pullup_disable_out(pud), .ctx_out(cx));

  ipc_core_model core (.mclk_in(mclk_in), .srst_in(srst_in), .vec_valid_in(vv),
    .delay_in(dly), .vec_ack_out(ack), .ctx_out(cc));

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (wk) wakes <= wakes + 1;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a <= `IPC_OFS_TMR0 && a[1:0] == 2'b00) ? 2'b00 : 2'b10;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    logic [1:0] b;
    @(posedge mclk_in);
    aa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do
    begin
      @(negedge mclk_in);
      ah = awv && awr;
      wh = wv && wr;
      bh = bv;
      b = br;
      @(posedge mclk_in);
      if (ah) awv <= 0;
      if (wh) wv <= 0;
    end while (!bh);
    bry <= 0;
    chk("write response", {30'h0, resp_of(a)}, {30'h0, b});
  endtask

  task automatic reg_rd(input logic [7:0] a);
    logic ah, got;
    logic [1:0] b;
    @(posedge mclk_in);
    aa <= a;
    arv <= 1;
    rry <= 1;
    do
    begin
      @(negedge mclk_in);
      ah = arv && arr;
      got = rv;
      rd = rdo;
      b = rr;
      @(posedge mclk_in);
      if (ah) arv <= 0;
    end while (!got);
    rry <= 0;
    chk("read response", {30'h0, resp_of(a)}, {30'h0, b});
  endtask

  task automatic flag_chk(input logic [7:0] a, input int b, input logic e);
    repeat (3) @(posedge mclk_in);
    reg_rd(a);
    chk("flag", {31'h0, e}, {31'h0, rd[b]});
    reg_wr(`IPC_OFS_GCTRL, 8'h00);
    reg_wr(`IPC_OFS_XCTRL, 8'h00);
  endtask

  task automatic pin(input int i, input logic lv);
    @(posedge mclk_in);
    pins[i] <= lv;
  endtask

  task automatic pev_pulse;
    @(posedge mclk_in);
    pev[3] <= 8'h01;
    @(posedge mclk_in);
    pev[3] <= 8'h00;
  endtask

  task automatic pin_chk(input int i, input logic lv, input logic e);
    pin(i, lv);
    flag_chk(i == 0 ? `IPC_OFS_GCTRL : `IPC_OFS_XCTRL, i == 0 ? 1 : i - 1, e);
  endtask

  task automatic tmr(input logic [15:0] a, input logic [15:0] b);
    @(posedge mclk_in);
    t0 <= a;
    @(posedge mclk_in);
    t0 <= b;
  endtask

  task automatic vec_chk(input logic [15:0] e);
    int n;
    n = 0;
    while (vv !== 1'b1 && n < 40)
    begin
      @(negedge mclk_in);
      n++;
    end
    chk("vector", {15'h0, 1'b1, e}, {15'h0, vv, va});
    repeat (12) @(posedge mclk_in);
  endtask

  task automatic ret(input logic hi);
    @(posedge mclk_in);
    rh <= hi;
    rl <= !hi;
    @(posedge mclk_in);
    rh <= 0;
    rl <= 0;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    wrap_up;
  end

  initial
  begin
    repeat (20) @(posedge mclk_in);
    srst_in <= 0;
    for (int i = 0; i < 10; i++)
    begin
      reg_rd(ra[i]);
      chk("reset value", {24'h0, rv_tab[i]}, rd);
    end
    chk("pullup disable", 32'h1, {31'h0, pud});
    reg_wr(`IPC_OFS_PRI4, 8'hFF);
    reg_rd(`IPC_OFS_PRI4);
    chk("priority four", 32'h7, rd);
    reg_wr(`IPC_OFS_PRI5, 8'hFF);
    reg_rd(`IPC_OFS_PRI5);
    chk("priority five", 32'h7, rd);
    reg_wr(8'h7C, 8'hFF);
    reg_rd(8'h7C);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 3; i++)
    begin
      reg_wr(`IPC_OFS_ECTRL, 8'h40 >> i);
      pin_chk(i, 1, 1);
      pin_chk(i, 0, 0);
      reg_wr(`IPC_OFS_ECTRL, 8'h00);
      pin_chk(i, 1, 0);
      pin_chk(i, 0, 1);
    end
    chk("pullup disable", 32'h0, {31'h0, pud});
    tmr(16'h00FF, 16'h0100);
    flag_chk(`IPC_OFS_GCTRL, `IPC_G_T0F, 1);
    reg_wr(`IPC_OFS_TMR0, 8'h01);
    tmr(16'h01FF, 16'h0200);
    flag_chk(`IPC_OFS_GCTRL, `IPC_G_T0F, 0);
    tmr(16'hFFFF, 16'h0000);
    flag_chk(`IPC_OFS_GCTRL, `IPC_G_T0F, 1);
    reg_wr(`IPC_OFS_TMR0, 8'h00);
    reg_wr(`IPC_OFS_PCHG, 8'hF0);
    for (int j = 4; j < 8; j++)
    begin
      @(posedge mclk_in);
      pb[j] <= 1;
      flag_chk(`IPC_OFS_GCTRL, `IPC_G_PCF, 1);
    end
    reg_wr(`IPC_OFS_GCTRL, 8'hA0);
    tmr(16'h00FF, 16'h0100);
    vec_chk(`IPC_VEC_HIGH);
    chk("return address", {16'h0, cc.ret_pc}, {16'h0, cx.ret_pc});
    chk("saved registers", {8'h0, cc[23:0]}, {8'h0, cx[23:0]});
    flag_chk(`IPC_OFS_GCTRL, `IPC_G_T0F, 1);
    ret(1);
    dly <= 4'h7;
    reg_wr(`IPC_OFS_RSTC, 8'h80);
    reg_wr(`IPC_OFS_GCTRL, 8'hF0);
    tmr(16'h00FF, 16'h0100);
    vec_chk(`IPC_VEC_LOW);
    pin(0, 1);
    pin(0, 0);
    vec_chk(`IPC_VEC_HIGH);
    reg_wr(`IPC_OFS_GCTRL, 8'hF0);
    ret(1);
    ret(0);
    reg_wr(`IPC_OFS_GCTRL, 8'h10);
    lp <= 1;
    pin(0, 1);
    pin(0, 0);
    repeat (10) @(posedge mclk_in);
    chk("wake pulses", 32'h1, 32'(wakes));
    chk("no vector", 32'h0, {31'h0, vv});
    reg_wr(`IPC_OFS_GCTRL, 8'h00);
    lp <= 0;
    pin(0, 1);
    @(posedge mclk_in);
    lp <= 1;
    pin(0, 0);
    repeat (10) @(posedge mclk_in);
    chk("wake pulses", 32'h1, 32'(wakes));
    lp <= 0;
    reg_wr(`IPC_OFS_EN4, 8'h01);
    reg_wr(`IPC_OFS_GCTRL, 8'hC0);
    pev_pulse;
    vec_chk(`IPC_VEC_HIGH);
    reg_wr(`IPC_OFS_FLG4, 8'h00);
    ret(1);
    reg_wr(`IPC_OFS_PRI4, 8'h00);
    pev_pulse;
    vec_chk(`IPC_VEC_LOW);
    reg_wr(`IPC_OFS_FLG4, 8'h00);
    ret(0);
    reg_wr(`IPC_OFS_ECTRL, 8'h01);
    reg_wr(`IPC_OFS_GCTRL, 8'h88);
    @(posedge mclk_in);
    pb[4] <= 0;
    vec_chk(`IPC_VEC_HIGH);
    wrap_up;
  end
endmodule
